//--- rate_filter_pkg.sv
// shared constants and carriers for the rate-adaptive decimation filter
package rate_filter_pkg;
  // output rates are given in units of 0.1 kS/s
  localparam int RATE_W = 12;
  localparam logic [11:0] RATE_MIN = 12'h001;
  localparam logic [11:0] RATE_AAF_LOW_MAX = 12'h014;
  localparam logic [11:0] RATE_BAND0_MAX = 12'h200;
  localparam logic [11:0] RATE_BAND1_MAX = 12'h400;
  localparam logic [11:0] RATE_MAX = 12'h7d0;
  // oversampling ratios per band
  localparam logic [8:0] OSR_BAND0 = 9'h100;
  localparam logic [8:0] OSR_BAND1 = 9'h080;
  localparam logic [8:0] OSR_BAND2 = 9'h040;
  // converter latency in output-sample periods
  localparam logic [3:0] DELAY_BAND0 = 4'hc;
  localparam logic [3:0] DELAY_BAND1 = 4'h9;
  localparam logic [3:0] DELAY_BAND2 = 4'h5;
  // analogue corner in kHz
  localparam logic [6:0] AAF_LOW_KHZ = 7'h05;
  localparam logic [6:0] AAF_HIGH_KHZ = 7'h64;
  // -3 dB bandwidth in thousandths of fs
  localparam logic [9:0] BW_BAND0 = 10'h1ee;
  localparam logic [9:0] BW_BAND1 = 10'h1ea;
  localparam logic [9:0] BW_BAND2 = 10'h17c;
  localparam int DATA_W = 16;
  localparam int ACC_W = 28;
  localparam int TAPS = 4;
  localparam int DLY_DEPTH = 16;

  typedef enum logic [1:0] {band_low, band_mid, band_top} band_e;

  typedef struct packed {
    band_e band;
    logic [8:0] osr;
    logic [3:0] delay;
    logic [6:0] aaf_khz;
    logic [9:0] bw_milli;
    logic [11:0] cutoff;
  } regime_s;

  // maps an output rate to its full filter regime
  function automatic regime_s pick_regime(input logic [11:0] rate);
    regime_s r;
    r.cutoff = {1'b0, rate[11:1]};
    r.aaf_khz = (rate <= RATE_AAF_LOW_MAX) ? AAF_LOW_KHZ : AAF_HIGH_KHZ;
    if (rate <= RATE_BAND0_MAX) begin
      r.band = band_low;
      r.osr = OSR_BAND0;
      r.delay = DELAY_BAND0;
      r.bw_milli = BW_BAND0;
    end else if (rate <= RATE_BAND1_MAX) begin
      r.band = band_mid;
      r.osr = OSR_BAND1;
      r.delay = DELAY_BAND1;
      r.bw_milli = BW_BAND1;
    end else begin
      r.band = band_top;
      r.osr = OSR_BAND2;
      r.delay = DELAY_BAND2;
      r.bw_milli = BW_BAND2;
    end
    return r;
  endfunction
endpackage

//--- rate_adaptive_decimation_filter.sv
// rate-adaptive decimating fir with regime selection and latency compensation
`timescale 1ns/1ps
module rate_adaptive_decimation_filter
  import rate_filter_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [11:0] rate_sel,
  input wire logic mod_bit,
  input wire logic mod_valid,
  output logic [15:0] out_data,
  output logic out_valid,
  output logic [31:0] out_stamp,
  output logic [6:0] aaf_corner_khz,
  output regime_s regime_active,
  output logic rate_error
);
  // the modulator bit and the rate word arrive from another domain
  logic bit_s1, bit_s2, vld_s1, vld_s2, vld_s3;
  logic next_bit_s1, next_bit_s2, next_vld_s1, next_vld_s2, next_vld_s3;
  logic [11:0] rate_s1, rate_s2, next_rate_s1, next_rate_s2;

  regime_s cur, next_cur;
  regime_s want;
  logic [8:0] cnt, next_cnt;
  logic [ACC_W-1:0] acc, next_acc;
  logic [DATA_W-1:0] hist [TAPS];
  logic [DATA_W-1:0] next_hist [TAPS];
  logic [DATA_W-1:0] dec;
  logic [DATA_W+1:0] sum;
  logic [15:0] next_out_data;
  logic next_out_valid;
  logic [31:0] out_idx, next_out_idx, next_out_stamp;
  logic next_rate_error;
  logic in_strobe;
  logic boundary;

  // symmetric taps keep the phase linear; the gain is 6/4 on a steady input in the low and mid bands, 1 in the top band
  function automatic logic [DATA_W+1:0] fir_sum(input logic [DATA_W-1:0] a0, a1, a2, a3);
    return {2'b00, a0} + {1'b0, a1, 1'b0} + {1'b0, a2, 1'b0} + {2'b00, a3};
  endfunction

  // synchroniser group: the logic reads the second stages and the third stage of the valid
  always_comb begin
    next_bit_s1 = mod_bit;
    next_bit_s2 = bit_s1;
    next_vld_s1 = mod_valid;
    next_vld_s2 = vld_s1;
    next_vld_s3 = vld_s2;
    next_rate_s1 = rate_sel;
    next_rate_s2 = rate_s1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bit_s1 <= 1'b0;
      bit_s2 <= 1'b0;
      vld_s1 <= 1'b0;
      vld_s2 <= 1'b0;
      vld_s3 <= 1'b0;
      rate_s1 <= RATE_MIN;
      rate_s2 <= RATE_MIN;
    end else if (ce) begin
      bit_s1 <= next_bit_s1;
      bit_s2 <= next_bit_s2;
      vld_s1 <= next_vld_s1;
      vld_s2 <= next_vld_s2;
      vld_s3 <= next_vld_s3;
      rate_s1 <= next_rate_s1;
      rate_s2 <= next_rate_s2;
    end
  end

  // a modulator sample counts on the rising edge of its valid level
  assign in_strobe = vld_s2 & ~vld_s3;
  // the last sample of a group closes it
  assign boundary = in_strobe && (cnt == cur.osr - 9'h001);
  // the regime only takes the rate word at a boundary, so a torn update never lands inside a group
  assign want = pick_regime(rate_s2);

  // decimator group
  always_comb begin
    next_cur = cur;
    next_cnt = cnt;
    next_acc = acc;
    dec = '0;
    if (in_strobe) begin
      // +1 counts as 2 and -1 as 0, so the sum never goes negative
      next_acc = acc + (bit_s2 ? ACC_W'(2) : ACC_W'(0));
      next_cnt = cnt + 9'h001;
    end
    if (boundary) begin
      // one decimated value per ratio inputs
      dec = DATA_W'((next_acc << 8) >> cur.osr[8:6]);
      next_acc = '0;
      next_cnt = '0;
      next_cur = want;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cur <= pick_regime(RATE_MIN);
      cnt <= '0;
      acc <= '0;
    end else if (ce) begin
      cur <= next_cur;
      cnt <= next_cnt;
      acc <= next_acc;
    end
  end

  // fir group
  always_comb begin
    next_hist = hist;
    sum = '0;
    if (boundary) begin
      if (cur.band == band_top) begin
        // top band keeps only the middle taps, giving the narrower response
        sum = {1'b0, hist[0], 1'b0} + {1'b0, hist[1], 1'b0};
      end else begin
        sum = fir_sum(dec, hist[0], hist[1], hist[2]);
      end
      next_hist[0] = dec;
      for (int i = 1; i < TAPS; i++) begin
        next_hist[i] = hist[i-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < TAPS; i++) begin
        hist[i] <= '0;
      end
    end else if (ce) begin
      hist <= next_hist;
    end
  end

  // output data group
  always_comb begin
    next_out_data = out_data;
    next_out_valid = 1'b0;
    if (boundary) begin
      next_out_data = sum[DATA_W+1:2];
      next_out_valid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_data <= '0;
      out_valid <= 1'b0;
    end else if (ce) begin
      out_data <= next_out_data;
      out_valid <= next_out_valid;
    end
  end

  // stamp group: the stamp wraps, so hosts must compare stamps modulo 2^32
  always_comb begin
    next_out_idx = out_idx;
    next_out_stamp = out_stamp;
    if (boundary) begin
      next_out_idx = out_idx + 32'h00000001;
      // stamp names the input instant, latency removed
      next_out_stamp = out_idx - {28'h0000000, cur.delay};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_idx <= '0;
      out_stamp <= '0;
    end else if (ce) begin
      out_idx <= next_out_idx;
      out_stamp <= next_out_stamp;
    end
  end

  // rate flag group: an out-of-range rate still maps to a band
  always_comb begin
    next_rate_error = (rate_s2 < RATE_MIN) || (rate_s2 > RATE_MAX);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rate_error <= 1'b0;
    end else if (ce) begin
      rate_error <= next_rate_error;
    end
  end

  assign aaf_corner_khz = cur.aaf_khz;
  assign regime_active = cur;
endmodule // rate_adaptive_decimation_filter

//--- rate_filter_sva.sv
// checker for the rate-adaptive decimation filter
`timescale 1ns/1ps
module rate_filter_sva
  import rate_filter_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] out_data,
  input wire logic out_valid,
  input wire logic [6:0] aaf_corner_khz,
  input wire regime_s regime_active
);
  wire regime_s g = regime_active;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_osr_low: assert property (g.band == band_low |-> g.osr == OSR_BAND0) else $error("osr");
  chk_osr_mid: assert property (g.band == band_mid |-> g.osr == OSR_BAND1) else $error("osr");
  chk_osr_top: assert property (g.band == band_top |-> g.osr == OSR_BAND2) else $error("osr");
  chk_delay_low: assert property (g.band == band_low |-> g.delay == DELAY_BAND0) else $error("delay");
  chk_corner_port: assert property (aaf_corner_khz == g.aaf_khz) else $error("corner");
  chk_valid_gap: assert property (out_valid |=> !out_valid [*8]) else $error("gap");
  chk_regime_hold: assert property (!out_valid |-> $stable(g)) else $error("regime");
  chk_data_hold: assert property (!out_valid |-> $stable(out_data)) else $error("data");
endmodule // rate_filter_sva
bind rate_adaptive_decimation_filter rate_filter_sva i_sva (.clk(clk), .rstn(rstn), .out_data(out_data),
  .out_valid(out_valid), .aaf_corner_khz(aaf_corner_khz), .regime_active(regime_active));

//--- mod_source.sv
// modulator bitstream model
`timescale 1ns/1ps
module mod_source (
  input wire logic clk,
  input wire logic en,
  input wire logic ones,
  output logic mod_bit = 1'b1,
  output logic mod_valid = 1'b0
);
  // fastest legal cadence, one sample every two cycles
  always @(posedge clk) begin
    #2 mod_valid <= en & ~mod_valid;
    mod_bit <= ones;
  end
endmodule // mod_source

//--- test_rate_adaptive_decimation_filter.sv
// bench for the rate-adaptive decimation filter
`timescale 1ns/1ps
module test_rate_adaptive_decimation_filter;
  import rate_filter_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, en = 1'b0, mod_bit, mod_valid, out_valid, rate_error;
  logic ce = 1'b1, ones = 1'b1;
  logic [15:0] out_data;
  logic [11:0] rate_sel = 12'h001;
  logic [31:0] out_stamp;
  logic [6:0] aaf_corner_khz;
  regime_s regime_active;
  int n_mismatch = 0, checks = 0, nout = 0;
  always #10 clk = ~clk;
  mod_source i_src (.clk(clk), .en(en), .ones(ones), .mod_bit(mod_bit), .mod_valid(mod_valid));
  rate_adaptive_decimation_filter i_dut (.clk(clk), .rstn(rstn), .ce(ce), .rate_sel(rate_sel), .mod_bit(mod_bit),
    .mod_valid(mod_valid), .out_data(out_data), .out_valid(out_valid), .out_stamp(out_stamp),
    .aaf_corner_khz(aaf_corner_khz), .regime_active(regime_active), .rate_error(rate_error));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // n is the cycle count from the call to the next output
  task automatic wait_out(output int n);
    for (n = 1; n < 2000; n++) begin
      @(negedge clk);
      if (out_valid === 1'b1) break;
    end
    nout++;
    if (n == 2000) begin
      cmp(0, 1);
      end_sim;
    end
  endtask
  // band edges from both sides, the corner edge and one rate past the ceiling
  task automatic t_rates;
    logic [11:0] r[8] = '{12'h014, 12'h015, 12'h200, 12'h201, 12'h400, 12'h401, 12'h7d0, 12'h7d1};
    int n, b;
    for (int i = 0; i < 8; i++) begin
      b = (i > 2) + (i > 4);
      @(posedge clk) #2 rate_sel = r[i];
      repeat (4) @(posedge clk);
      wait_out(n);
      wait_out(n);
      cmp(n, 512 >> b);
      cmp(regime_active.bw_milli, b == 0 ? BW_BAND0 : b == 1 ? BW_BAND1 : BW_BAND2);
      cmp(aaf_corner_khz, r[i] <= 12'h014 ? 5 : 100);
      cmp(regime_active.cutoff, r[i] >> 1);
      cmp(out_stamp, nout - 1 - (b == 0 ? 12 : b == 1 ? 9 : 5));
      cmp(rate_error, i == 7);
    end
    $display("t_rates done");
  endtask
  // new rate and bit level, then six outputs so the whole tap history is in the new stream
  task automatic set_stream(input logic [11:0] r, input logic b);
    int n;
    @(posedge clk) #2 rate_sel = r;
    ones = b;
    repeat (6) wait_out(n);
  endtask
  // steady streams through the low and top band responses
  task automatic t_data;
    set_stream(12'h100, 1'b1);
    cmp(out_data, 32'h00003000);
    set_stream(12'h100, 1'b0);
    cmp(out_data, 32'h00000000);
    set_stream(12'h7d0, 1'b1);
    cmp(out_data, 32'h00004000);
    cmp(out_stamp, nout - 1 - 5);
    $display("t_data done");
  endtask
  // a low clock enable freezes the stream
  task automatic t_hold;
    logic [31:0] stamp;
    int seen;
    seen = 0;
    stamp = out_stamp;
    @(posedge clk) #2 ce = 1'b0;
    repeat (600) begin
      @(negedge clk);
      if (out_valid === 1'b1) seen++;
    end
    cmp(seen, 0);
    cmp(out_stamp, stamp);
    @(posedge clk) #2 ce = 1'b1;
    $display("t_hold done");
  endtask
  // mid-run reset, then a rate below the floor
  task automatic t_reset;
    int n;
    @(posedge clk) #2 rstn = 1'b0;
    rate_sel = 12'h000;
    repeat (2) @(posedge clk);
    #2 rstn = 1'b1;
    nout = 0;
    @(negedge clk);
    cmp(out_stamp, 0);
    cmp(regime_active.osr, OSR_BAND0);
    cmp(aaf_corner_khz, 5);
    repeat (3) @(negedge clk);
    cmp(rate_error, 1);
    wait_out(n);
    cmp(out_stamp, 32'hfffffff4);
    $display("t_reset done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #2 rstn = 1'b1;
    en = 1'b1;
    t_rates;
    t_data;
    t_hold;
    t_reset;
    end_sim;
  end
endmodule // test_rate_adaptive_decimation_filter
